// >>> design/sfpd_cfg.svh
// Purpose: offsets, field positions, reset values and limits of the spindle function decoder
// Assumes: apb byte addresses, one register per aligned 32-bit word
// Notes: registers are 16 bits wide, the upper half reads as zero
// Notes on behaviour
// - overshoot field: 00 stops, 11 is type 3, 01 and 10 prohibited
// - lost motion field bits 9-8: 00 stops, 10 is type 2, others prohibited
// - bit 7 of word 1 picks normal or changed lost motion timing
// - jitter field bits 5-4: 00 off, else one to three pulses
// - notch depth code 000 infinite, then -18.1 down to -1.2 decibels
// - word 2 depth fields: F-D filter 5, B-9 filter 4, 7-5 filter 2, 3-1 filter 1
// - word 2 bit 8 picks standard or high frequency current control
// - word 3 bit C starts high-gain feed in interpolation; host clears it with alt feed
// - interpolation: word 3 bit A picks excitation 2, bit 9 gain set 2
// - non-interpolation: word 3 bits 2 and 1 apply only after in-position
// - synchronization: word 4 bit 7 forces the high-speed coil
// - word 4 bit 4 starts high-gain feed in synchronization; host clears with alt feed
// - synchronization: word 4 bit 2 picks excitation 2, bit 1 gain set 2
// - notch 1 frequency 0 to 2250 Hz, acts only at 50 or more
// - lost motion band is signed thousandths of degree, zero means two
// - overshoot amount applies only with type 3, range -1 to 100 percent
// - second amount 0 uses first both ways; -1 suppresses that direction
// - fine flag widens ranges to 10000 and 20000 hundredths of percent
// - multi-axis variant: emergency stop field reads 19 normal, 59 enabled
// - resistor variant: bits 7-4 value 0 disables, 4 enables stop function
`ifndef SFPD_CFG_SVH
`define SFPD_CFG_SVH
`define SFPD_OFF_TYPE      12'h000
`define SFPD_OFF_FUNC1     12'h004
`define SFPD_OFF_FUNC2     12'h008
`define SFPD_OFF_FUNC3     12'h00C
`define SFPD_OFF_FUNC4     12'h010
`define SFPD_OFF_INERTIA   12'h014
`define SFPD_OFF_NOTCH1F   12'h018
`define SFPD_OFF_LMTIME    12'h01C
`define SFPD_OFF_LMBAND    12'h020
`define SFPD_OFF_LMAMT2    12'h024
`define SFPD_OFF_OVERSHOOT_AMOUNT_MINUS      12'h028
`define SFPD_OFF_OVERSHOOT_AMOUNT_PLUS      12'h02C
`define SFPD_OFF_CTRL      12'h030
`define SFPD_OFF_STATUS    12'h034
`define SFPD_RST_WORD      16'h0000
`define SFPD_NOTCH_MAX     16'h08CA
`define SFPD_NOTCH_MIN     16'h0032
`define SFPD_BAND_DEFAULT  16'h0002
`define SFPD_OVS_MAX       16'h0064
`define SFPD_OVS_MAX_FINE  16'h2710
`define SFPD_LMC_MAX       16'h00C8
`define SFPD_LMC_MAX_FINE  16'h4E20
`define SFPD_MINUS_ONE     16'hFFFF
`define SFPD_ESTOP_NORMAL  8'h19
`define SFPD_ESTOP_ENABLED 8'h59
`define SFPD_EMGX_OFF      4'h0
`define SFPD_EMGX_ON       4'h4
`define SFPD_VAR_SINGLE    2'b00
`define SFPD_VAR_MULTI     2'b01
`define SFPD_VAR_RESISTOR  2'b10
`endif

// >>> design/sfpd_pkg.sv
// Purpose: types of the spindle function decoder
// Assumes: constants come from sfpd_cfg.svh
// Notes: depth enum carries the three-bit notch code
package sfpd_pkg;
  typedef enum logic [2:0] {
    SFPD_DEPTH_INF = 3'h0, SFPD_DEPTH_18P1 = 3'h1, SFPD_DEPTH_12P0 = 3'h2,
    SFPD_DEPTH_8P5 = 3'h3, SFPD_DEPTH_6P0 = 3'h4, SFPD_DEPTH_4P1 = 3'h5,
    SFPD_DEPTH_2P5 = 3'h6, SFPD_DEPTH_1P2 = 3'h7
  } sfpd_depth_t;
  typedef enum logic [2:0] {
    SFPD_MODE_NONINT = 3'b001, SFPD_MODE_INTERP = 3'b010, SFPD_MODE_SYNC = 3'b100
  } sfpd_mode_t;
endpackage

// >>> design/sfpd_decoder.sv
// Purpose: apb register bank decoding spindle function parameter words
// Assumes: one clock pclk, async active-low presetn, zero-wait apb slave
// Notes: decoded selections are registered outputs, refreshed every cycle
`timescale 1ns/100ps
`include "sfpd_cfg.svh"
`default_nettype none
module sfpd_decoder
  import sfpd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        in_position,
  input  wire logic [2:0]  mode_sel,
  output logic      [1:0]  overshoot_type,
  output logic      [1:0]  lost_motion_type,
  output logic             lost_motion_timing_sel,
  output logic      [1:0]  jitter_pulses,
  output logic      [2:0]  notch5_depth,
  output logic      [2:0]  notch4_depth,
  output logic      [2:0]  notch2_depth,
  output logic      [2:0]  notch1_depth,
  output logic             high_freq_current,
  output logic             fixed_notch_enable,
  output logic             high_gain_feed_control,
  output logic             excitation_rate2,
  output logic             speed_gain_set2,
  output logic             high_speed_coil,
  output logic             notch1_active,
  output logic      [15:0] lost_motion_band,
  output logic             overshoot_active,
  output logic      [15:0] overshoot_amount_plus,
  output logic      [15:0] overshoot_amount_minus,
  output logic      [15:0] lost_motion_amount_minus,
  output logic             estop_enabled,
  output logic             config_error
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when a two-bit overshoot code is one of its prohibited settings, 01 or 10
  function automatic logic ovs_bad(input logic [1:0] c);
    return (c == 2'b01) || (c == 2'b10);
  endfunction

  // signed range check used for every amount limit
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] hi);
    return ($signed(v) >= $signed(`SFPD_MINUS_ONE)) && ($signed(v) <= $signed(hi));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [15:0] type_q, f1_q, f2_q, f3_q, f4_q, inertia_q, notchf_q;
  logic [15:0] lmtime_q, lmband_q, lmamt2_q, overshoot_amount_minus_q, overshoot_amount_plus_q;
  logic        fine_q;
  logic [1:0]  variant_q;
  logic        err_sticky_q;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        bad_write;
  logic [15:0] wdat;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  // low halfword lanes only; upper strobes change nothing
  assign wdat  = pwdata[15:0];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `SFPD_OFF_STATUS);

  // prohibited codes detected on the incoming word itself
  always_comb begin
    bad_write = 1'b0;
    if (wr_en && paddr == `SFPD_OFF_FUNC1) begin
      // lost motion code 10 is type 2, so only 01 and 11 (low bit set) are prohibited
      bad_write = ovs_bad(wdat[11:10]) || wdat[8];
    end else if (wr_en && paddr == `SFPD_OFF_TYPE && variant_q == `SFPD_VAR_RESISTOR) begin
      bad_write = (wdat[7:4] != `SFPD_EMGX_OFF) && (wdat[7:4] != `SFPD_EMGX_ON);
    end
  end

  // parameter words; every write with both low strobes set takes effect in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_q    <= `SFPD_RST_WORD;
      f1_q      <= `SFPD_RST_WORD;
      f2_q      <= `SFPD_RST_WORD;
      f3_q      <= `SFPD_RST_WORD;
      f4_q      <= `SFPD_RST_WORD;
      inertia_q <= `SFPD_RST_WORD;
      notchf_q  <= `SFPD_RST_WORD;
      lmtime_q  <= `SFPD_RST_WORD;
      lmband_q  <= `SFPD_RST_WORD;
      lmamt2_q  <= `SFPD_RST_WORD;
      overshoot_amount_minus_q    <= `SFPD_RST_WORD;
      overshoot_amount_plus_q    <= `SFPD_RST_WORD;
      fine_q    <= 1'b0;
      variant_q <= `SFPD_VAR_SINGLE;
    end else if (wr_en && (pstrb[1:0] == 2'b11)) begin
      unique case (paddr)
        `SFPD_OFF_TYPE:    type_q    <= wdat;
        `SFPD_OFF_FUNC1:   f1_q      <= wdat;
        `SFPD_OFF_FUNC2:   f2_q      <= wdat;
        `SFPD_OFF_FUNC3:   f3_q      <= wdat;
        `SFPD_OFF_FUNC4:   f4_q      <= wdat;
        `SFPD_OFF_INERTIA: inertia_q <= wdat;
        `SFPD_OFF_NOTCH1F: notchf_q  <= wdat;
        `SFPD_OFF_LMTIME:  lmtime_q  <= wdat;
        `SFPD_OFF_LMBAND:  lmband_q  <= wdat;
        `SFPD_OFF_LMAMT2:  lmamt2_q  <= wdat;
        `SFPD_OFF_OVERSHOOT_AMOUNT_MINUS:    overshoot_amount_minus_q    <= wdat;
        `SFPD_OFF_OVERSHOOT_AMOUNT_PLUS:    overshoot_amount_plus_q    <= wdat;
        `SFPD_OFF_CTRL: begin
          fine_q    <= wdat[0];
          variant_q <= wdat[5:4];
        end
        default: ;
      endcase
    end
  end

  // sticky error flag: a new prohibited write wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_sticky_q <= 1'b0;
    end else if (bad_write) begin
      err_sticky_q <= 1'b1;
    end else if (wr_en && paddr == `SFPD_OFF_STATUS && wdat[0]) begin
      err_sticky_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: zero wait states, read data registered in setup

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        unique case (paddr)
          `SFPD_OFF_TYPE:    prdata <= {16'h0000, type_q};
          `SFPD_OFF_FUNC1:   prdata <= {16'h0000, f1_q};
          `SFPD_OFF_FUNC2:   prdata <= {16'h0000, f2_q};
          `SFPD_OFF_FUNC3:   prdata <= {16'h0000, f3_q};
          `SFPD_OFF_FUNC4:   prdata <= {16'h0000, f4_q};
          `SFPD_OFF_INERTIA: prdata <= {16'h0000, inertia_q};
          `SFPD_OFF_NOTCH1F: prdata <= {16'h0000, notchf_q};
          `SFPD_OFF_LMTIME:  prdata <= {16'h0000, lmtime_q};
          `SFPD_OFF_LMBAND:  prdata <= {16'h0000, lmband_q};
          `SFPD_OFF_LMAMT2:  prdata <= {16'h0000, lmamt2_q};
          `SFPD_OFF_OVERSHOOT_AMOUNT_MINUS:    prdata <= {16'h0000, overshoot_amount_minus_q};
          `SFPD_OFF_OVERSHOOT_AMOUNT_PLUS:    prdata <= {16'h0000, overshoot_amount_plus_q};
          `SFPD_OFF_CTRL:    prdata <= {26'h0, variant_q, 3'h0, fine_q};
          `SFPD_OFF_STATUS:  prdata <= {28'h0, estop_enabled, notch1_active,
                                        overshoot_active, err_sticky_q};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // in-position is asynchronous to pclk: two flops before use

  logic inpos_m_q, inpos_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inpos_m_q <= 1'b0;
      inpos_q   <= 1'b0;
    end else begin
      inpos_m_q <= in_position;
      inpos_q   <= inpos_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // function word 1 and 2 decode; prohibited codes fall back to stopped

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overshoot_type         <= 2'b00;
      lost_motion_type       <= 2'b00;
      lost_motion_timing_sel <= 1'b0;
      jitter_pulses          <= 2'b00;
      notch5_depth           <= 3'h0;
      notch4_depth           <= 3'h0;
      notch2_depth           <= 3'h0;
      notch1_depth           <= 3'h0;
      high_freq_current      <= 1'b0;
      fixed_notch_enable     <= 1'b0;
    end else begin
      // holding off a prohibited code is safer than guessing a type
      overshoot_type         <= (f1_q[11:10] == 2'b11) ? 2'b11 : 2'b00;
      lost_motion_type       <= (f1_q[9:8] == 2'b10) ? 2'b10 : 2'b00;
      lost_motion_timing_sel <= f1_q[7];
      jitter_pulses          <= f1_q[5:4];
      // depth codes pass as-is; sfpd_depth_t names the attenuation
      notch5_depth           <= sfpd_depth_t'(f2_q[15:13]);
      notch4_depth           <= sfpd_depth_t'(f2_q[11:9]);
      notch2_depth           <= sfpd_depth_t'(f2_q[7:5]);
      notch1_depth           <= sfpd_depth_t'(f2_q[3:1]);
      high_freq_current      <= f2_q[8];
      fixed_notch_enable     <= f2_q[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode-dependent selections

  logic ex2_d, vg2_d, shg_d;
  always_comb begin
    ex2_d = 1'b0;
    vg2_d = 1'b0;
    shg_d = 1'b0;
    unique case (mode_sel)
      SFPD_MODE_INTERP: begin
        shg_d = f3_q[12];
        ex2_d = f3_q[10];
        vg2_d = f3_q[9];
      end
      SFPD_MODE_SYNC: begin
        shg_d = f4_q[4];
        ex2_d = f4_q[2];
        vg2_d = f4_q[1];
      end
      SFPD_MODE_NONINT: begin
        ex2_d = f3_q[2] && inpos_q;
        vg2_d = f3_q[1] && inpos_q;
      end
      default: ;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_gain_feed_control <= 1'b0;
      excitation_rate2       <= 1'b0;
      speed_gain_set2        <= 1'b0;
      high_speed_coil        <= 1'b0;
    end else begin
      high_gain_feed_control <= shg_d;
      excitation_rate2       <= ex2_d;
      speed_gain_set2        <= vg2_d;
      high_speed_coil        <= (mode_sel == SFPD_MODE_SYNC) && f4_q[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scalar limits and directional amounts

  logic [15:0] ovs_max, lmc_max;
  assign ovs_max = fine_q ? `SFPD_OVS_MAX_FINE : `SFPD_OVS_MAX;
  assign lmc_max = fine_q ? `SFPD_LMC_MAX_FINE : `SFPD_LMC_MAX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      notch1_active            <= 1'b0;
      lost_motion_band         <= 16'h0000;
      overshoot_active         <= 1'b0;
      overshoot_amount_plus    <= 16'h0000;
      overshoot_amount_minus   <= 16'h0000;
      lost_motion_amount_minus <= 16'h0000;
      estop_enabled            <= 1'b0;
      config_error             <= 1'b0;
    end else begin
      // values above the range leave the filter off rather than misbehave
      notch1_active    <= (notchf_q >= `SFPD_NOTCH_MIN) && (notchf_q <= `SFPD_NOTCH_MAX);
      lost_motion_band <= (lmband_q == 16'h0000) ? `SFPD_BAND_DEFAULT : lmband_q;
      overshoot_active <= (f1_q[11:10] == 2'b11) && in_range(overshoot_amount_plus_q, ovs_max);
      // -1 passes out unchanged so the loop skips that direction
      overshoot_amount_plus  <= overshoot_amount_plus_q;
      overshoot_amount_minus <= (overshoot_amount_minus_q == 16'h0000) ? overshoot_amount_plus_q : overshoot_amount_minus_q;
      lost_motion_amount_minus <= in_range(lmamt2_q, lmc_max) ? lmamt2_q : 16'h0000;
      unique case (variant_q)
        `SFPD_VAR_MULTI:    estop_enabled <= (type_q[7:0] == `SFPD_ESTOP_ENABLED);
        `SFPD_VAR_RESISTOR: estop_enabled <= (type_q[7:4] == `SFPD_EMGX_ON);
        default:            estop_enabled <= 1'b0;
      endcase
      config_error <= err_sticky_q;
    end
  end

endmodule
`default_nettype wire

// >>> sim/sfpd_asserts.sv
// Purpose: concurrent checks on the spindle function decoder ports
// Assumes: zero-wait apb, decoded outputs settle two edges after a write
// Notes: attached by bind, watches top-level ports only
`timescale 1ns/100ps
`include "sfpd_cfg.svh"
`default_nettype none
module sfpd_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  overshoot_type,
  input wire logic [1:0]  lost_motion_type,
  input wire logic        lost_motion_timing_sel,
  input wire logic [1:0]  jitter_pulses,
  input wire logic [2:0]  notch5_depth,
  input wire logic [2:0]  notch4_depth,
  input wire logic [2:0]  notch2_depth,
  input wire logic [2:0]  notch1_depth,
  input wire logic        high_freq_current,
  input wire logic        fixed_notch_enable,
  input wire logic        config_error
);
  logic [15:0] wd1_q;
  logic [15:0] wd2_q;
  // committed full-width writes only; narrow strobes are dropped by the slave
  wire logic wr = psel & penable & pwrite & pready & ~pslverr & (pstrb[1:0] == 2'h3);
  wire logic w1 = wr & (paddr == `SFPD_OFF_FUNC1);
  wire logic w2 = wr & (paddr == `SFPD_OFF_FUNC2);
  // two-deep copy of write data lines up with the decoded outputs
  always_ff @(posedge pclk) begin
    wd1_q <= pwdata[15:0];
    wd2_q <= wd1_q;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  zero_wait_a: assert property (psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  ovs_decode_a: assert property (w1 |-> ##2 overshoot_type == {2{&wd2_q[11:10]}})
    else $error("overshoot type decode wrong");
  lm_decode_a: assert property (w1 |=> ##1 lost_motion_type == {wd2_q[9] & ~wd2_q[8], 1'b0})
    else $error("lost motion type decode wrong");
  timing_sel_a: assert property (w1 |-> ##2 lost_motion_timing_sel == wd2_q[7])
    else $error("lost motion timing select wrong");
  jitter_count_a: assert property (w1 |-> ##2 jitter_pulses == wd2_q[5:4])
    else $error("jitter pulse count wrong");
  depth_fields_a: assert property (w2 |-> ##2 {notch5_depth, notch4_depth, notch2_depth,
    notch1_depth} == {wd2_q[15:13], wd2_q[11:9], wd2_q[7:5], wd2_q[3:1]})
    else $error("notch depth fields misplaced");
  current_mode_a: assert property (w2 |-> ##2 high_freq_current == wd2_q[8])
    else $error("current control select wrong");
  fixed_notch_a: assert property (w2 |=> ##1 fixed_notch_enable == wd2_q[4])
    else $error("fixed notch enable wrong");
  cfg_error_a: assert property (w1 && (^pwdata[11:10] || pwdata[8]) |-> ##2 config_error)
    else $error("prohibited code not flagged");
endmodule
bind sfpd_decoder sfpd_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .pslverr, .overshoot_type, .lost_motion_type,
  .lost_motion_timing_sel, .jitter_pulses, .notch5_depth, .notch4_depth, .notch2_depth,
  .notch1_depth, .high_freq_current, .fixed_notch_enable, .config_error);
`default_nettype wire

// >>> sim/tb_spindle_function_param_decoder.sv
// Purpose: self-checking bench for the spindle function decoder
// Assumes: zero-wait apb slave, outputs follow a write by two edges
// Notes: pstrb stays full; narrow strobe writes are not exercised
`timescale 1ns/100ps
`include "sfpd_cfg.svh"
`default_nettype none
module tb_spindle_function_param_decoder;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, in_position, rerr;
  logic        lost_motion_timing_sel, high_freq_current, fixed_notch_enable, notch1_active;
  logic        high_gain_feed_control, excitation_rate2, speed_gain_set2, high_speed_coil;
  logic        overshoot_active, estop_enabled, config_error;
  logic [1:0]  overshoot_type, lost_motion_type, jitter_pulses;
  logic [2:0]  mode_sel, notch5_depth, notch4_depth, notch2_depth, notch1_depth;
  logic [3:0]  pstrb;
  logic [11:0] paddr;
  logic [15:0] d, lost_motion_band, overshoot_amount_plus, overshoot_amount_minus;
  logic [15:0] lost_motion_amount_minus;
  logic [31:0] pwdata, prdata, rdat;
  int          err_count, n_checks;
  logic [15:0] nf_v [5] = '{16'h0000, 16'h0031, 16'h0032, 16'h08CA, 16'h08CB};
  logic [15:0] ov_v [5] = '{16'h0064, 16'h0065, 16'hFFFF, 16'h2710, 16'h2711};
  logic [15:0] et_v [4] = '{16'h0059, 16'h0019, 16'h0040, 16'h0000};

  sfpd_decoder dut_u (.*);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; the wait for pready is bounded so a dead slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] v);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, v};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      complete_run;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hF;
    in_position = 0; mode_sel = 3'h2; presetn = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // parameter words clear at reset, band still reads as two thousandths
    for (int a = 0; a < 12; a++) begin
      apb(0, 12'(a * 4), 16'h0000);
      chk(rdat, 32'h0);
    end
    chk(lost_motion_band, 16'h0002);
    // unmapped and unaligned places answer with an error
    apb(0, 12'h038, 16'h0000); chk(rerr, 1'b1);
    apb(0, 12'h005, 16'h0000); chk(rerr, 1'b1);
    // every overshoot and lost motion code, prohibited ones included
    for (int i = 0; i < 16; i++) begin
      d = {4'h0, i[3:0], i[0], 1'b0, i[1:0], 4'h0};
      apb(1, `SFPD_OFF_FUNC1, d); settle;
      chk(overshoot_type, {2{i[3] & i[2]}});
      chk(lost_motion_type, {i[1] & ~i[0], 1'b0});
      chk(lost_motion_timing_sel, i[0]);
      chk(jitter_pulses, i[1:0]);
      chk(config_error, (i[3] ^ i[2]) | i[0]);
      apb(1, `SFPD_OFF_STATUS, 16'h0001);
    end
    // all eight depth codes in all four fields
    for (int k = 0; k < 8; k++) begin
      d = {k[2:0], 1'b0, k[2:0], k[0], k[2:0], k[1], k[2:0], 1'b0};
      apb(1, `SFPD_OFF_FUNC2, d); settle;
      chk({notch5_depth, notch4_depth, notch2_depth, notch1_depth}, {4{k[2:0]}});
      chk(high_freq_current, k[0]);
      chk(fixed_notch_enable, k[1]);
    end
    // the last depth word written must read back unchanged
    apb(0, `SFPD_OFF_FUNC2, 16'h0000);
    chk(rdat, {16'h0000, d});
    // mode selections; non-interpolation waits for the synchronised in-position
    apb(1, `SFPD_OFF_FUNC3, 16'h1606);
    apb(1, `SFPD_OFF_FUNC4, 16'h0096); settle;
    chk({high_gain_feed_control, excitation_rate2, speed_gain_set2}, 3'h7);
    mode_sel <= 3'h1; repeat (6) @(posedge pclk);
    chk({excitation_rate2, speed_gain_set2}, 2'h0);
    in_position <= 1'b1; repeat (6) @(posedge pclk);
    chk({excitation_rate2, speed_gain_set2}, 2'h3);
    mode_sel <= 3'h4; settle;
    chk({high_speed_coil, high_gain_feed_control, excitation_rate2, speed_gain_set2}, 4'hF);
    apb(1, `SFPD_OFF_FUNC4, 16'h0000); settle;
    chk({high_speed_coil, high_gain_feed_control, excitation_rate2, speed_gain_set2}, 4'h0);
    // notch frequency limits and a nonzero band passing through unchanged
    for (int j = 0; j < 5; j++) begin
      apb(1, `SFPD_OFF_NOTCH1F, nf_v[j]); settle;
      chk(notch1_active, j == 2 || j == 3);
    end
    apb(1, `SFPD_OFF_LMBAND, 16'h8000); settle;
    chk(lost_motion_band, 16'h8000);
    // overshoot amount limits, normal then fine resolution
    apb(1, `SFPD_OFF_FUNC1, 16'h0C00);
    for (int j = 0; j < 5; j++) begin
      apb(1, `SFPD_OFF_CTRL, {15'h0000, j > 2});
      apb(1, `SFPD_OFF_OVERSHOOT_AMOUNT_PLUS, ov_v[j]); settle;
      chk(overshoot_active, j != 1 && j != 4);
    end
    apb(1, `SFPD_OFF_OVERSHOOT_AMOUNT_PLUS, 16'h0032); apb(1, `SFPD_OFF_OVERSHOOT_AMOUNT_MINUS, 16'h0000); settle;
    chk({overshoot_amount_plus, overshoot_amount_minus}, 32'h00320032);
    apb(1, `SFPD_OFF_LMAMT2, 16'h4E20); settle;
    chk(lost_motion_amount_minus, 16'h4E20);
    apb(1, `SFPD_OFF_CTRL, 16'h0000); settle;
    chk(lost_motion_amount_minus, 16'h0000);
    apb(1, `SFPD_OFF_FUNC1, 16'h0000); settle;
    chk(overshoot_active, 1'b0);
    // emergency stop codes of the multi-axis and resistor variants
    for (int j = 0; j < 4; j++) begin
      apb(1, `SFPD_OFF_CTRL, j < 2 ? 16'h0010 : 16'h0020);
      apb(1, `SFPD_OFF_TYPE, et_v[j]); settle;
      chk(estop_enabled, j == 0 || j == 2);
    end
    apb(1, `SFPD_OFF_TYPE, 16'h0030); settle;
    chk(config_error, 1'b1);
    // status shows only the sticky error: stop, notch and overshoot all off here
    apb(0, `SFPD_OFF_STATUS, 16'h0000);
    chk(rdat, 32'h0000_0001);
    complete_run;
  end
endmodule
`default_nettype wire
